// ===== config_word_pkg.sv
// constants and types shared by the configuration word decoder
package config_word_pkg;

  localparam int WORD_W = 14;
  localparam int PADDR_W = 20;

  // register indices; byte address is four times the index
  localparam logic [17:0] IDX_WORD_ONE = 18'h0_8007;
  localparam logic [17:0] IDX_WORD_TWO = 18'h0_8008;
  localparam logic [17:0] IDX_STATUS = 18'h0_8009;

  // erased state of a configuration word
  localparam logic [13:0] WORD_ERASED = 14'h3fff;
  // word two bits that are not implemented and read as one
  localparam logic [13:0] WORD_TWO_ONES = 14'h08ec;

  // word one field positions
  localparam int W1_FAIL_MON = 13;
  localparam int W1_SWITCHOVER = 12;
  localparam int W1_CLKOUT_N = 11;
  localparam int W1_BROWNOUT_HI = 10;
  localparam int W1_BROWNOUT_LO = 9;
  localparam int W1_DATA_PROT_N = 8;
  localparam int W1_PROG_PROT_N = 7;
  localparam int W1_RESET_PIN = 6;
  localparam int W1_PWRUP_N = 5;
  localparam int W1_WATCHDOG_HI = 4;
  localparam int W1_WATCHDOG_LO = 3;
  localparam int W1_OSC_HI = 2;
  localparam int W1_OSC_LO = 0;

  // word two field positions
  localparam int W2_LOW_VOLT = 13;
  localparam int W2_DEBUG_N = 12;
  localparam int W2_BROWNOUT_LVL = 10;
  localparam int W2_STACK_RESET = 9;
  localparam int W2_PLL = 8;
  localparam int W2_RESERVED = 4;
  localparam int W2_WRT_HI = 1;
  localparam int W2_WRT_LO = 0;

  // status register bits
  localparam int ST_PROG_MODE = 0;
  localparam int ST_LV_ENTRY = 1;
  localparam int ST_PENDING = 2;

  // self-write protection limits
  localparam int ADDR_W = 12;
  localparam logic [11:0] WRT_TOP_SMALL = 12'h1ff;
  localparam logic [11:0] WRT_TOP_MID_2K = 12'h3ff;
  localparam logic [11:0] WRT_TOP_MID_4K = 12'h7ff;
  localparam logic [11:0] WRT_TOP_ALL_2K = 12'h7ff;
  localparam logic [11:0] WRT_TOP_ALL_4K = 12'hfff;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SW = 2'b01,
    MODE_RUN = 2'b10,
    MODE_ON = 2'b11
  } enable_mode_type;

  typedef enum logic [1:0] {
    WRT_ALL = 2'b00,
    WRT_MID = 2'b01,
    WRT_SMALL = 2'b10,
    WRT_NONE = 2'b11
  } wrt_range_type;

  typedef enum logic [2:0] {
    OSC_LP = 3'b000,
    OSC_XT = 3'b001,
    OSC_HS = 3'b010,
    OSC_EXTRC = 3'b011,
    OSC_INTOSC = 3'b100,
    OSC_ECL = 3'b101,
    OSC_ECM = 3'b110,
    OSC_ECH = 3'b111
  } osc_type;

endpackage : config_word_pkg

// ===== level_sync.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage_r;
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          stage_r <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage_r <= async_in[i];
          sync_out[i] <= stage_r;
        end
      end
    end
  endgenerate

endmodule : level_sync

// ===== write_range_decode.sv
// maps the self-write protection field to a protected address span
`timescale 1ns/100ps
module write_range_decode #(
  parameter bit LARGE_PART = 1'b1
) (
  input wire logic [1:0] range_sel,
  output logic protect_any,
  output logic [11:0] protect_top
);

  always_comb begin
    protect_any = 1'b1;
    protect_top = 12'h000;
    case (range_sel)
      config_word_pkg::WRT_NONE: begin
        protect_any = 1'b0;
      end
      config_word_pkg::WRT_SMALL: begin
        protect_top = config_word_pkg::WRT_TOP_SMALL;
      end
      config_word_pkg::WRT_MID: begin
        protect_top = LARGE_PART ? config_word_pkg::WRT_TOP_MID_4K
                                 : config_word_pkg::WRT_TOP_MID_2K;
      end
      config_word_pkg::WRT_ALL: begin
        protect_top = LARGE_PART ? config_word_pkg::WRT_TOP_ALL_4K
                                 : config_word_pkg::WRT_TOP_ALL_2K;
      end
      default: begin
        protect_any = 1'b0;
      end
    endcase
  end

endmodule : write_range_decode

// ===== config_word_decode.sv
// configuration word storage, reset-time capture and decode, with apb access
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module config_word_decode #(
  parameter bit LARGE_PART = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic prog_mode_pin,
  input wire logic lv_entry_pin,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic clock_fail_monitor_en,
  output logic int_ext_switchover_en,
  output logic clock_out_active,
  output logic brownout_run_en,
  output logic brownout_sleep_en,
  output logic sw_brownout_enable,
  output logic brownout_level_low,
  output logic data_protect_on,
  output logic program_protect_on,
  output logic reset_pin_is_reset,
  output logic reset_pin_pullup_forced,
  output logic powerup_timer_en,
  output logic watchdog_run_en,
  output logic watchdog_sleep_en,
  output logic sw_watchdog_enable,
  output logic [2:0] oscillator_select,
  output logic osc_crystal_mode,
  output logic osc_external_clock,
  output logic clock_in_pin_io,
  output logic low_volt_prog_en,
  output logic debugger_en,
  output logic stack_fault_reset_en,
  output logic pll_multiply_en,
  output logic self_write_protect_any,
  output logic [11:0] self_write_protect_top,
  output logic program_erase_req,
  output logic data_erase_req
);

  logic [13:0] word_one_r;
  logic [13:0] word_two_r;
  logic [13:0] hold_one_r;
  logic [13:0] hold_two_r;
  logic [1:0] pin_sync;
  logic prog_mode_s;
  logic lv_entry_s;
  logic [13:0] wdata;
  logic sel_one;
  logic sel_two;
  logic sel_status;
  logic access;
  logic commit;
  logic req_err;
  logic [31:0] rdata_nxt;
  logic wrt_any;
  logic [11:0] wrt_top;
  logic [2:0] osc_sel;
  logic crystal;
  logic [1:0] bo_mode;
  logic [1:0] wd_mode;
  logic ext_clock;
  logic int_osc;
  logic pending_r;
  logic [1:0][1:0] mode_field;
  logic [1:0] mode_run_r;
  logic [1:0] mode_sleep_r;
  logic [1:0] mode_sw_r;

  level_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({lv_entry_pin, prog_mode_pin}),
    .sync_out(pin_sync)
  );

  assign prog_mode_s = pin_sync[0];
  assign lv_entry_s = pin_sync[1];
  assign wdata = pwdata[13:0];

  // ---------------- apb decode ----------------
  assign sel_one = (paddr[1:0] == 2'b00) &&
                   (paddr[19:2] == config_word_pkg::IDX_WORD_ONE);
  assign sel_two = (paddr[1:0] == 2'b00) &&
                   (paddr[19:2] == config_word_pkg::IDX_WORD_TWO);
  assign sel_status = (paddr[1:0] == 2'b00) &&
                      (paddr[19:2] == config_word_pkg::IDX_STATUS);

  // first access cycle prepares the answer, second one completes it
  assign access = psel && penable && !pready;
  assign commit = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    req_err = 1'b0;
    if (!(sel_one || sel_two || sel_status)) begin
      req_err = 1'b1;
    end else if (pwrite) begin
      if (sel_status || !prog_mode_s) begin
        req_err = 1'b1;
      end else if (sel_two && lv_entry_s && !wdata[config_word_pkg::W2_LOW_VOLT]) begin
        req_err = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (sel_one) begin
      rdata_nxt[13:0] = word_one_r;
    end else if (sel_two) begin
      rdata_nxt[13:0] = word_two_r | config_word_pkg::WORD_TWO_ONES;
    end else if (sel_status) begin
      rdata_nxt[config_word_pkg::ST_PROG_MODE] = prog_mode_s;
      rdata_nxt[config_word_pkg::ST_LV_ENTRY] = lv_entry_s;
      rdata_nxt[config_word_pkg::ST_PENDING] = pending_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access) begin
      pready <= 1'b1;
      pslverr <= req_err;
      prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ---------------- non-volatile storage ----------------
  // only the power-on clear erases storage; an ordinary reset keeps it
  always_ff @(posedge ref_clk) begin
    if (por) begin
      word_one_r <= config_word_pkg::WORD_ERASED;
      word_two_r <= config_word_pkg::WORD_ERASED;
    end else if (commit && sel_one) begin
      word_one_r <= wdata;
    end else if (commit && sel_two) begin
      word_two_r <= wdata | config_word_pkg::WORD_TWO_ONES;
    end
  end

  // lifting protection wipes the protected memory
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      program_erase_req <= 1'b0;
    end else begin
      program_erase_req <= commit && sel_one &&
                           !word_one_r[config_word_pkg::W1_PROG_PROT_N] &&
                           wdata[config_word_pkg::W1_PROG_PROT_N];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      data_erase_req <= 1'b0;
    end else begin
      data_erase_req <= commit && sel_one &&
                        !word_one_r[config_word_pkg::W1_DATA_PROT_N] &&
                        wdata[config_word_pkg::W1_DATA_PROT_N];
    end
  end

  // ---------------- reset-time capture ----------------
  always_ff @(posedge ref_clk) begin
    if (por) begin
      hold_one_r <= config_word_pkg::WORD_ERASED;
      hold_two_r <= config_word_pkg::WORD_ERASED;
    end else if (rst) begin
      hold_one_r <= word_one_r;
      hold_two_r <= word_two_r;
    end
  end

  // new words only take effect at the next reset; flag them for software
  always_ff @(posedge ref_clk) begin
    if (rst || por) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= (word_one_r != hold_one_r) || (word_two_r != hold_two_r);
    end
  end

  // ---------------- decode ----------------
  assign osc_sel = hold_one_r[config_word_pkg::W1_OSC_HI:config_word_pkg::W1_OSC_LO];
  assign bo_mode = hold_one_r[config_word_pkg::W1_BROWNOUT_HI:config_word_pkg::W1_BROWNOUT_LO];
  assign wd_mode = hold_one_r[config_word_pkg::W1_WATCHDOG_HI:config_word_pkg::W1_WATCHDOG_LO];
  assign mode_field[0] = bo_mode;
  assign mode_field[1] = wd_mode;

  // crystal modes leave the clock-out pin to the oscillator
  always_comb begin
    crystal = 1'b0;
    ext_clock = 1'b0;
    int_osc = 1'b0;
    case (osc_sel)
      config_word_pkg::OSC_LP,
      config_word_pkg::OSC_XT,
      config_word_pkg::OSC_HS: begin
        crystal = 1'b1;
      end
      config_word_pkg::OSC_INTOSC: begin
        int_osc = 1'b1;
      end
      config_word_pkg::OSC_ECL,
      config_word_pkg::OSC_ECM,
      config_word_pkg::OSC_ECH: begin
        ext_clock = 1'b1;
      end
      default: begin
        crystal = 1'b0;
      end
    endcase
  end

  write_range_decode #(
    .LARGE_PART(LARGE_PART)
  ) u_wrt (
    .range_sel(hold_two_r[config_word_pkg::W2_WRT_HI:config_word_pkg::W2_WRT_LO]),
    .protect_any(wrt_any),
    .protect_top(wrt_top)
  );

  // clock features
  always_ff @(posedge ref_clk) begin
    clock_fail_monitor_en <= hold_one_r[config_word_pkg::W1_FAIL_MON];
    int_ext_switchover_en <= hold_one_r[config_word_pkg::W1_SWITCHOVER];
    clock_out_active <= !crystal && !hold_one_r[config_word_pkg::W1_CLKOUT_N];
    pll_multiply_en <= hold_two_r[config_word_pkg::W2_PLL];
  end

  // clock source
  always_ff @(posedge ref_clk) begin
    oscillator_select <= osc_sel;
    osc_crystal_mode <= crystal;
    osc_external_clock <= ext_clock;
    clock_in_pin_io <= int_osc;
  end

  // brown-out and watchdog share one mode encoding, one decoder per field
  genvar m;
  generate
    for (m = 0; m < 2; m++) begin : g_mode
      always_ff @(posedge ref_clk) begin
        case (mode_field[m])
          config_word_pkg::MODE_ON: begin
            mode_run_r[m] <= 1'b1;
            mode_sleep_r[m] <= 1'b1;
            mode_sw_r[m] <= 1'b0;
          end
          config_word_pkg::MODE_RUN: begin
            mode_run_r[m] <= 1'b1;
            mode_sleep_r[m] <= 1'b0;
            mode_sw_r[m] <= 1'b0;
          end
          config_word_pkg::MODE_SW: begin
            mode_run_r[m] <= 1'b0;
            mode_sleep_r[m] <= 1'b0;
            mode_sw_r[m] <= 1'b1;
          end
          default: begin
            mode_run_r[m] <= 1'b0;
            mode_sleep_r[m] <= 1'b0;
            mode_sw_r[m] <= 1'b0;
          end
        endcase
      end
    end
  endgenerate

  assign brownout_run_en = mode_run_r[0];
  assign brownout_sleep_en = mode_sleep_r[0];
  assign sw_brownout_enable = mode_sw_r[0];
  assign watchdog_run_en = mode_run_r[1];
  assign watchdog_sleep_en = mode_sleep_r[1];
  assign sw_watchdog_enable = mode_sw_r[1];

  // brown-out level
  always_ff @(posedge ref_clk) begin
    brownout_level_low <= hold_two_r[config_word_pkg::W2_BROWNOUT_LVL];
  end

  // power-up timer, decoded apart from the brown-out mode
  always_ff @(posedge ref_clk) begin
    powerup_timer_en <= !hold_one_r[config_word_pkg::W1_PWRUP_N];
  end

  // stack fault reset
  always_ff @(posedge ref_clk) begin
    stack_fault_reset_en <= hold_two_r[config_word_pkg::W2_STACK_RESET];
  end

  // code protection
  always_ff @(posedge ref_clk) begin
    data_protect_on <= !hold_one_r[config_word_pkg::W1_DATA_PROT_N];
    program_protect_on <= !hold_one_r[config_word_pkg::W1_PROG_PROT_N];
  end

  // programming and debug
  always_ff @(posedge ref_clk) begin
    low_volt_prog_en <= hold_two_r[config_word_pkg::W2_LOW_VOLT];
    debugger_en <= !hold_two_r[config_word_pkg::W2_DEBUG_N];
  end

  // self-write protection
  always_ff @(posedge ref_clk) begin
    self_write_protect_any <= wrt_any;
    self_write_protect_top <= wrt_top;
  end

  // with low-voltage programming the pin stays a reset input
  always_ff @(posedge ref_clk) begin
    reset_pin_is_reset <= hold_two_r[config_word_pkg::W2_LOW_VOLT] ||
                          hold_one_r[config_word_pkg::W1_RESET_PIN];
    reset_pin_pullup_forced <= hold_two_r[config_word_pkg::W2_LOW_VOLT] ||
                               hold_one_r[config_word_pkg::W1_RESET_PIN];
  end

endmodule : config_word_decode

// ===== cw_decode_chk.sv
// assertions on the configuration word decoder ports
`timescale 1ns/100ps
module cw_decode_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic por,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clock_out_active,
  input wire logic brownout_run_en,
  input wire logic brownout_sleep_en,
  input wire logic sw_brownout_enable,
  input wire logic watchdog_run_en,
  input wire logic watchdog_sleep_en,
  input wire logic sw_watchdog_enable,
  input wire logic [2:0] oscillator_select,
  input wire logic osc_crystal_mode,
  input wire logic clock_in_pin_io,
  input wire logic self_write_protect_any,
  input wire logic [11:0] self_write_protect_top,
  input wire logic program_erase_req,
  input wire logic data_erase_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // outputs only move two edges after a reset or power-on capture
  property p_hold;
    !$past(rst, 2) && !$past(rst) && !$past(por, 2) |->
      $stable({oscillator_select, self_write_protect_top, clock_out_active});
  endproperty
  a_hold: assert property (p_hold) else $error("decoded outputs moved");
  property p_clkout;
    clock_out_active |-> !osc_crystal_mode;
  endproperty
  a_clkout: assert property (p_clkout) else $error("clock out in crystal mode");
  property p_osc;
    osc_crystal_mode == (oscillator_select < 3'h3) && clock_in_pin_io == (oscillator_select == 3'h4);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator decode");
  property p_bor;
    !(sw_brownout_enable && brownout_run_en) && (!brownout_sleep_en || brownout_run_en);
  endproperty
  a_bor: assert property (p_bor) else $error("brown-out mode decode");
  property p_wdt;
    watchdog_sleep_en |-> watchdog_run_en ##0 !sw_watchdog_enable;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog mode decode");
  property p_wrt;
    self_write_protect_any == (self_write_protect_top != 12'h000) &&
      self_write_protect_top inside {12'h000, 12'h1ff, 12'h7ff, 12'hfff};
  endproperty
  a_wrt: assert property (p_wrt) else $error("write protect span");
  property p_ready;
    psel && $rose(penable) |-> !pready ##1 pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb wait state");
  property p_perase;
    program_erase_req |->
      ($past(pready) && !$past(pslverr) && $past(paddr) == 20'h2_001c) ##1 !program_erase_req;
  endproperty
  a_perase: assert property (p_perase) else $error("program erase pulse");
  property p_derase;
    data_erase_req |-> $past(pwrite) && $past(pready) && $past(paddr) == 20'h2_001c;
  endproperty
  a_derase: assert property (p_derase) else $error("data erase pulse");
  c_err: cover property (pslverr);
  c_erase: cover property (program_erase_req);
  c_clkout: cover property (clock_out_active);
endmodule : cw_decode_chk

bind config_word_decode cw_decode_chk i_chk (.*);

// ===== cw_prog_model.sv
// device programmer model: apb master and programming pins
`timescale 1ns/100ps
module cw_prog_model (
  input wire logic ref_clk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [19:0] paddr,
  output logic [31:0] pwdata,
  output logic prog_mode_pin,
  output logic lv_entry_pin
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, prog_mode_pin, lv_entry_pin} = '0;
  end
  task automatic xfer(input logic w, input logic [17:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= (idx == config_word_pkg::IDX_WORD_TWO) ? (d | 32'h0000_0010) : d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // pins pass a two-flop sync before they count
  task automatic pins(input logic pm, input logic lv);
    @(posedge ref_clk);
    prog_mode_pin <= pm;
    lv_entry_pin <= lv;
    repeat (3) @(posedge ref_clk);
  endtask : pins
endmodule : cw_prog_model

// ===== tb_top.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic por = 1'h1;
  logic psel, penable, pwrite, pready, pslverr, prog_mode_pin, lv_entry_pin, e;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic clock_fail_monitor_en, int_ext_switchover_en, clock_out_active, brownout_run_en;
  logic brownout_sleep_en, sw_brownout_enable, brownout_level_low, data_protect_on;
  logic program_protect_on, reset_pin_is_reset, reset_pin_pullup_forced, powerup_timer_en;
  logic watchdog_run_en, watchdog_sleep_en, sw_watchdog_enable, osc_crystal_mode;
  logic osc_external_clock, clock_in_pin_io, low_volt_prog_en, debugger_en;
  logic stack_fault_reset_en, pll_multiply_en, self_write_protect_any;
  logic program_erase_req, data_erase_req;
  logic [2:0] oscillator_select, v;
  logic [11:0] self_write_protect_top;
  logic [13:0] w1, w2, p;
  int n_fail = 0;
  int n_tests = 0;
  wire [37:0] outs = {clock_fail_monitor_en, int_ext_switchover_en, clock_out_active,
    brownout_run_en, brownout_sleep_en, sw_brownout_enable, brownout_level_low,
    data_protect_on, program_protect_on, reset_pin_is_reset, reset_pin_pullup_forced,
    powerup_timer_en, watchdog_run_en, watchdog_sleep_en, sw_watchdog_enable,
    oscillator_select, osc_crystal_mode, osc_external_clock, clock_in_pin_io,
    low_volt_prog_en, debugger_en, stack_fault_reset_en, pll_multiply_en,
    self_write_protect_any, self_write_protect_top};

  always #10 ref_clk = ~ref_clk;

  config_word_decode i_dut (.*);
  cw_prog_model i_prog (.*);

  function automatic logic [37:0] dec(input logic [13:0] a, input logic [13:0] b);
    logic x;
    logic [11:0] t;
    x = a[2:0] < 3'h3;
    t = b[1:0] == 2'h2 ? 12'h1ff : b[1:0] == 2'h1 ? 12'h7ff : b[1:0] == 2'h0 ? 12'hfff : 12'h0;
    return {a[13], a[12], !a[11] & !x, a[10], &a[10:9], a[10:9] == 2'h1, b[10], !a[8], !a[7],
      b[13] | a[6], b[13] | a[6], !a[5], a[4], &a[4:3], a[4:3] == 2'h1, a[2:0], x,
      a[2:0] > 3'h4, a[2:0] == 3'h4, b[13], !b[12], b[9], b[8], b[1:0] != 2'h3, t};
  endfunction : dec

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic acc(input logic w, input logic [17:0] idx, input logic [31:0] d, input logic ee);
    i_prog.xfer(w, idx, d, q, e);
    check("pslverr", e, ee);
  endtask : acc

  task automatic rd(input logic [17:0] idx, input logic [31:0] exp);
    acc(1'h0, idx, 32'h0, 1'h0);
    check("prdata", q, exp);
  endtask : rd

  task automatic reboot;
    @(posedge ref_clk);
    rst <= 1'h1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (2) @(posedge ref_clk);
  endtask : reboot

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    p = 14'h3fff;
    repeat (3) @(posedge ref_clk);
    rst <= 1'h0;
    por <= 1'h0;
    repeat (2) @(posedge ref_clk);
    check("erased", outs, dec(14'h3fff, 14'h3fff));
    rd(config_word_pkg::IDX_WORD_ONE, 32'h0000_3fff);
    rd(config_word_pkg::IDX_WORD_TWO, 32'h0000_3fff);
    acc(1'h1, config_word_pkg::IDX_WORD_ONE, 32'h0, 1'h1);
    $display("test reset done");
    i_prog.pins(1'h1, 1'h0);
    acc(1'h0, 18'h0_8010, 32'h0, 1'h1);
    acc(1'h1, config_word_pkg::IDX_STATUS, 32'h0, 1'h1);
    $display("test refusal done");
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      w1 = {v[0], ~v[0], v[1], v[1:0], ~v[1], v[2], v[0], ~v[2], ~v[1:0], v};
      // debugger bit cleared on purpose for half the passes
      w2 = {~v[1], v[2], 1'h0, v[0], v[1], ~v[0], 3'h0, 1'h0, 2'h0, v[1:0]};
      acc(1'h1, config_word_pkg::IDX_WORD_ONE, {18'h0, w1}, 1'h0);
      @(posedge ref_clk);
      check("prog_erase", program_erase_req, !p[7] & w1[7]);
      check("data_erase", data_erase_req, !p[8] & w1[8]);
      p = w1;
      acc(1'h1, config_word_pkg::IDX_WORD_TWO, {18'h0, w2}, 1'h0);
      rd(config_word_pkg::IDX_WORD_ONE, {18'h0, w1});
      rd(config_word_pkg::IDX_WORD_TWO, {18'h0, w2 | 14'h08fc});
      rd(config_word_pkg::IDX_STATUS, 32'h0000_0005);
      reboot();
      check("decode", outs, dec(w1, w2 | 14'h0010));
      rd(config_word_pkg::IDX_STATUS, 32'h0000_0001);
    end
    $display("test decode done");
    i_prog.pins(1'h1, 1'h1);
    rd(config_word_pkg::IDX_STATUS, 32'h0000_0003);
    acc(1'h1, config_word_pkg::IDX_WORD_TWO, 32'h0000_1fff, 1'h1);
    rd(config_word_pkg::IDX_WORD_TWO, {18'h0, w2 | 14'h08fc});
    acc(1'h1, config_word_pkg::IDX_WORD_TWO, 32'h0000_3fff, 1'h0);
    $display("test low voltage done");
    test_done();
  end

  initial begin
    #100_000;
    n_fail++;
    test_done();
  end
endmodule : tb_top
